// >>> src/spi_frame_pkg.sv
// Constants, types and CRC helper for the framed serial peripheral port
// Notes on behaviour
// RL1: Output changes on rise, input sampled on fall.
// RL2: Select high floats output; select fall drives low.
// RL3: Output holds last bit, low on extra clocks.
// RL4: Ready falls on new data from chosen converter.
// RL5: Ready low in reset, high when port ready.
// RL6: Frame spans select fall to select rise.
// RL7: Input opens with command; output opens with status.
// RL8: Basic commands use four-word frames.
// RL9: Write frames lengthen; read reply follows next frame.
// RL10: Words 24 or 32 bits, MSB first, zero padded.
// RL11: Content widths 16 or 24 bits; read adds address.
// RL12: Status is high half plus upper low byte.
// RL13: Link fault flags report previous frame only.
// RL14: Other fault flags latch until host clears.
// RL15: Device flags sampled at frame start.
// RL16: Response field names last executed command.
// RL17: Three CRCs: command, write data, output.
// RL18: CRC mismatch executes nothing, flags fault.
// RL19: One polynomial select for all CRCs.
// RL20: Every CRC starts from all ones.
// RL21: No-op is zero; soft reset fixed code.
// RL22: Lock limits commands; unlock releases.
// RL23: Write and read codes carry address, count.
// RL24: Ignore activity and reset frame when deselected.
// RL25: Clock idles low, launch rise, sample fall.
// RL26: Host sends no-op after a read command.
// RL27: CRC bits processed MSB first with padding.
package spi_frame_pkg;
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int READY_DELAY_NS = 1000;
    localparam int READY_DELAY_CYCLES = (READY_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    localparam logic [15:0] POLY_ANSI = 16'h8005;
    localparam logic [15:0] CMD_NOOP = 16'h0000;
    localparam logic [15:0] CMD_SOFT_RESET = 16'h0011;
    localparam logic [15:0] CMD_LOCK = 16'h0555;
    localparam logic [15:0] CMD_UNLOCK = 16'h0655;
    localparam logic [2:0] PREFIX_WRITE = 3'h3;
    localparam logic [2:0] PREFIX_READ = 3'h5;
    localparam logic [5:0] WORD_BITS_SHORT = 6'h18;
    localparam logic [5:0] WORD_BITS_LONG = 6'h20;
    localparam logic [5:0] BASIC_CRC_WORD = 6'h03;
    localparam logic [5:0] ADC_B_WORD = 6'h02;
    localparam logic [7:0] USER_REG_COUNT = 8'h20;
    localparam int MAX_WRITE = 8;
    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_LINK = 12'h008;
    localparam logic [11:0] OFS_USER_BASE = 12'h100;
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam int CFG_WIDE_BIT = 0;
    localparam int CFG_POLY_BIT = 1;
    localparam int CFG_READY_SRC_BIT = 2;
    localparam int STATUS_RESET_FLAG_BIT = 10;
    localparam logic [9:0] DEV_FLAGS_RESET = 10'h3ff;
    localparam logic [3:0] COMM_FLAGS_CLEAR = 4'hf;
    localparam int COMM_CHECK_BIT = 3;
    localparam int COMM_PERM_BIT = 0;
    localparam logic [2:0] PIN_IDLE = 3'h4;
    localparam logic [3:0] RESP_FIRST = 4'h0;
    localparam logic [3:0] RESP_NOOP = 4'h1;
    localparam logic [3:0] RESP_SOFT_RESET = 4'h2;
    localparam logic [3:0] RESP_LOCK = 4'h3;
    localparam logic [3:0] RESP_UNLOCK = 4'h4;
    localparam logic [3:0] RESP_WRITE = 4'h5;
    localparam logic [3:0] RESP_READ = 4'h6;

    typedef enum logic [2:0] {
        LINK_BOOT = 3'h1,
        LINK_IDLE = 3'h2,
        LINK_FRAME = 3'h4
    } link_state_type;

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din, input logic ansi);
        logic fb;
        fb = crc[15] ^ din;
        crc_step = {crc[14:0], 1'b0} ^ (fb ? (ansi ? POLY_ANSI : POLY_CCITT) : 16'h0000);
    endfunction : crc_step
endpackage : spi_frame_pkg

// >>> src/framed_spi_peripheral_crc.sv
// Framed serial peripheral port with command decode and CRC checking
`timescale 1ns/100ps
module framed_spi_peripheral_crc import spi_frame_pkg::*; (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic chip_select_low,
    input wire logic serial_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic sample_ready_n,
    input wire logic [23:0] adc_a_data,
    input wire logic adc_a_valid,
    input wire logic [23:0] adc_b_data,
    input wire logic adc_b_valid,
    input wire logic [9:0] device_fault,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata
);
    logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
    link_state_type state_r, state_nxt;
    logic [5:0] hold_r;
    logic [2:0] cfg_r;
    logic wide_r, poly_r;
    logic [23:0] status_snap_r, adc_a_r, adc_b_r, adc_a_snap_r, adc_b_snap_r;
    logic [31:0] in_sr_r;
    logic [5:0] in_bit_r, in_word_r, out_bit_r, out_word_r;
    logic [15:0] crc_in_r, crc_out_r, cmd_r, cmd_crc_r, data_crc_r;
    logic [15:0] wbuf [MAX_WRITE];
    logic [15:0] user_regs [32];
    logic lock_r, wr_armed_r, rst_armed_r, rd_req_r, rd_act_r;
    logic [7:0] rd_req_addr_r, rd_addr_r;
    logic [4:0] rd_req_last_r, rd_last_r;
    logic [3:0] resp_pend_r, resp_r, comm_pend_r, comm_r, conv_cnt_r;
    logic [9:0] dev_flag_n_r;
    logic reset_seen_n_r;

    // Pin filter: a level counts once the 2nd and 3rd stages agree
    wire [2:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
    wire [2:0] pin_f_nxt = (pin_agree & pin_s2_r) | (~pin_agree & pin_f_r);
    wire in_frame = state_r == LINK_FRAME;
    wire cs_rise = ~pin_f_r[2] & pin_f_nxt[2];
    wire frame_open = pin_f_r[2] & ~pin_f_nxt[2] & (state_r == LINK_IDLE);
    wire frame_end = cs_rise & in_frame;
    wire sclk_rise = in_frame & ~cs_rise & ~pin_f_r[1] & pin_f_nxt[1];
    wire sclk_fall = in_frame & ~cs_rise & pin_f_r[1] & ~pin_f_nxt[1];
    wire sdi_bit = pin_f_nxt[0];
    wire hold_done = hold_r == 6'(READY_DELAY_CYCLES - 1);

    wire [5:0] wlen = wide_r ? WORD_BITS_LONG : WORD_BITS_SHORT;
    wire [31:0] in_sr_nxt = {in_sr_r[30:0], sdi_bit};
    wire [15:0] in_top = wide_r ? in_sr_nxt[31:16] : in_sr_nxt[23:8];
    wire in_word_end = sclk_fall & (in_bit_r == wlen - 6'd1);
    wire [15:0] crc_in_nxt = crc_step(crc_in_r, sdi_bit, poly_r);

    wire is_write = (cmd_r[15:13] == PREFIX_WRITE) & (cmd_r[4:3] == 2'b00);
    wire is_read = cmd_r[15:13] == PREFIX_READ;
    wire cmd_end = in_word_end & (in_word_r == 6'd1);
    wire cmd_ok = in_top == cmd_crc_r;
    wire lock_safe = (cmd_r == CMD_NOOP) | (cmd_r == CMD_UNLOCK) | is_read;
    wire allow = rd_act_r ? (cmd_r == CMD_NOOP) : (~lock_r | lock_safe);
    wire [5:0] last_data = {3'b000, cmd_r[2:0]} + 6'd2;
    wire data_word = in_word_end & wr_armed_r & (in_word_r >= 6'd2) & (in_word_r <= last_data);
    wire wdata_crc_end = in_word_end & wr_armed_r & (in_word_r == last_data + 6'd1);
    wire data_ok = in_top == data_crc_r;
    wire wr_commit = wdata_crc_end & data_ok;
    // Soft reset takes effect on the last input edge of the output CRC word
    wire soft_rst = in_word_end & rst_armed_r & (in_word_r == BASIC_CRC_WORD);

    wire [15:0] status_high = {comm_r, lock_r, reset_seen_n_r, dev_flag_n_r};
    wire [15:0] status_low = {resp_r, conv_cnt_r, 8'h00};
    wire [23:0] status_word = {status_high, status_low[15:8]}; // [RL12]

    wire [5:0] crc_idx = rd_act_r ? {1'b0, rd_last_r} + 6'd2 : BASIC_CRC_WORD;
    wire [7:0] rd_addr_now = rd_addr_r + 8'(out_word_r - 6'd1);
    wire rd_addr_ok = rd_addr_now < USER_REG_COUNT;
    wire [23:0] reg_word = rd_addr_ok ? {user_regs[rd_addr_now[4:0]], rd_addr_now} : 24'h000000; // [RL11]
    wire [23:0] data_word_out = rd_act_r ? reg_word : (out_word_r == 6'd1 ? adc_a_snap_r : adc_b_snap_r);
    wire [23:0] out_content = (out_word_r == 6'd0) ? status_snap_r // [RL7]
        : (out_word_r == crc_idx) ? {crc_out_r, 8'h00}
        : (out_word_r > crc_idx) ? 24'h000000
        : data_word_out; // [RL8] [RL9]
    wire out_bit_val = (out_bit_r < 6'd24) & out_content[5'(6'd23 - out_bit_r)]; // [RL10]
    wire sel_valid = cfg_r[CFG_READY_SRC_BIT] ? adc_b_valid : adc_a_valid;
    wire b_sent = sclk_rise & ~rd_act_r & (out_word_r == ADC_B_WORD) & (out_bit_r == wlen - 6'd1);

    wire user_hit = (bus_addr[11:7] == OFS_USER_BASE[11:7]) & (bus_addr[1:0] == 2'b00);
    wire status_wr = bus_write & (bus_addr == OFS_STATUS);
    wire [9:0] dev_clear = status_wr ? bus_wdata[9:0] : 10'h000;
    wire [31:0] rd_mux = (bus_addr == OFS_CONFIG) ? {29'h0, cfg_r}
        : (bus_addr == OFS_STATUS) ? {8'h00, status_word}
        : (bus_addr == OFS_LINK) ? {27'h0, state_r, lock_r, rd_act_r}
        : user_hit ? {16'h0000, user_regs[bus_addr[6:2]]} : 32'h00000000;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
            pin_s3_r <= PIN_IDLE;
            pin_f_r <= PIN_IDLE;
        end else begin
            pin_s1_r <= {chip_select_low, serial_clk, serial_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r <= pin_f_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LINK_BOOT: if (hold_done && pin_f_nxt[2]) state_nxt = LINK_IDLE;
            LINK_IDLE: if (frame_open) state_nxt = LINK_FRAME; // [RL6]
            LINK_FRAME: begin
                if (soft_rst) state_nxt = LINK_BOOT;
                else if (cs_rise) state_nxt = LINK_IDLE; // [RL24]
            end
            default: state_nxt = LINK_BOOT;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= LINK_BOOT;
            hold_r <= 6'd0;
        end else begin
            state_r <= state_nxt;
            hold_r <= (state_r != LINK_BOOT || state_nxt != LINK_BOOT) ? 6'd0 : hold_r + {5'd0, ~hold_done};
        end
    end

    // Word size, polynomial and device flags are frozen for the whole frame
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wide_r <= 1'b0;
            poly_r <= 1'b0;
            status_snap_r <= 24'h000000;
            adc_a_snap_r <= 24'h000000;
            adc_b_snap_r <= 24'h000000;
        end else if (frame_open) begin
            wide_r <= cfg_r[CFG_WIDE_BIT]; // [RL10]
            poly_r <= cfg_r[CFG_POLY_BIT]; // [RL19]
            status_snap_r <= status_word; // [RL15]
            adc_a_snap_r <= adc_a_r;
            adc_b_snap_r <= adc_b_r;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            in_sr_r <= 32'h00000000;
            in_bit_r <= 6'd0;
            in_word_r <= 6'd0;
            crc_in_r <= CRC_SEED;
            cmd_r <= CMD_NOOP;
            cmd_crc_r <= CRC_SEED;
            data_crc_r <= CRC_SEED;
            for (int i = 0; i < MAX_WRITE; i++) wbuf[i] <= 16'h0000;
        end else if (frame_open) begin
            in_bit_r <= 6'd0;
            in_word_r <= 6'd0;
            crc_in_r <= CRC_SEED; // [RL20]
        end else if (sclk_fall) begin // [RL1] [RL25]
            in_sr_r <= in_sr_nxt;
            in_bit_r <= in_word_end ? 6'd0 : in_bit_r + 6'd1;
            if (in_word_end && in_word_r != 6'h3f) in_word_r <= in_word_r + 6'd1;
            // Command CRC covers word 0 only; data CRC restarts after word 1
            crc_in_r <= (in_word_end && in_word_r <= 6'd1) ? CRC_SEED : crc_in_nxt; // [RL17] [RL27]
            if (in_word_end && in_word_r == 6'd0) begin
                cmd_r <= in_top; // [RL7]
                cmd_crc_r <= crc_in_nxt;
            end
            if (in_word_end && in_word_r == last_data) data_crc_r <= crc_in_nxt;
            if (data_word) wbuf[3'(in_word_r - 6'd2)] <= in_top; // [RL9]
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lock_r <= 1'b0;
            wr_armed_r <= 1'b0;
            rst_armed_r <= 1'b0;
            rd_req_r <= 1'b0;
            rd_act_r <= 1'b0;
            rd_req_addr_r <= 8'h00;
            rd_addr_r <= 8'h00;
            rd_req_last_r <= 5'h00;
            rd_last_r <= 5'h00;
            resp_pend_r <= RESP_NOOP;
            resp_r <= RESP_FIRST;
            comm_pend_r <= COMM_FLAGS_CLEAR;
            comm_r <= COMM_FLAGS_CLEAR;
        end else if (soft_rst) begin
            lock_r <= 1'b0;
            rst_armed_r <= 1'b0;
            rd_req_r <= 1'b0;
            rd_act_r <= 1'b0;
            resp_pend_r <= RESP_NOOP;
            resp_r <= RESP_SOFT_RESET; // [RL16]
            comm_pend_r <= COMM_FLAGS_CLEAR;
            comm_r <= COMM_FLAGS_CLEAR;
        end else if (frame_end) begin
            resp_r <= resp_pend_r; // [RL16]
            resp_pend_r <= RESP_NOOP;
            comm_r <= comm_pend_r; // [RL13]
            comm_pend_r <= COMM_FLAGS_CLEAR;
            rd_act_r <= rd_req_r; // [RL9]
            rd_addr_r <= rd_req_addr_r;
            rd_last_r <= rd_req_last_r;
            rd_req_r <= 1'b0;
            wr_armed_r <= 1'b0;
            rst_armed_r <= 1'b0;
        end else if (cmd_end) begin
            if (!cmd_ok) begin
                comm_pend_r[COMM_CHECK_BIT] <= 1'b0; // [RL18]
            end else if (!allow) begin
                comm_pend_r[COMM_PERM_BIT] <= 1'b0; // [RL22]
            end else if (cmd_r == CMD_LOCK) begin
                lock_r <= 1'b1; // [RL22]
                resp_pend_r <= RESP_LOCK;
            end else if (cmd_r == CMD_UNLOCK) begin
                lock_r <= 1'b0;
                resp_pend_r <= RESP_UNLOCK;
            end else if (is_read) begin
                rd_req_r <= 1'b1; // [RL23]
                rd_req_addr_r <= cmd_r[12:5];
                rd_req_last_r <= cmd_r[4:0];
                resp_pend_r <= RESP_READ;
            end else if (is_write) begin
                wr_armed_r <= 1'b1; // [RL23]
            end else if (cmd_r == CMD_SOFT_RESET) begin
                rst_armed_r <= 1'b1; // [RL21]
            end
        end else if (wdata_crc_end) begin
            wr_armed_r <= 1'b0;
            if (data_ok) resp_pend_r <= RESP_WRITE;
            else comm_pend_r[COMM_CHECK_BIT] <= 1'b0; // [RL18]
        end
    end

    // Host writes land in the same array so that read replies see them
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 32; i++) user_regs[i] <= 16'h0000;
        end else if (soft_rst) begin
            for (int i = 0; i < 32; i++) user_regs[i] <= 16'h0000;
        end else begin
            if (bus_write && user_hit) user_regs[bus_addr[6:2]] <= bus_wdata[15:0];
            for (int i = 0; i < MAX_WRITE; i++) begin
                if (wr_commit && i <= int'(cmd_r[2:0]) && (cmd_r[12:5] + 8'(i)) < USER_REG_COUNT)
                    user_regs[5'(cmd_r[9:5] + 5'(i))] <= wbuf[i];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dev_flag_n_r <= DEV_FLAGS_RESET;
            reset_seen_n_r <= 1'b0;
            conv_cnt_r <= 4'h0;
            adc_a_r <= 24'h000000;
            adc_b_r <= 24'h000000;
            sample_ready_n <= 1'b0; // [RL5]
        end else begin
            // A fault in the clearing cycle keeps its flag low
            dev_flag_n_r <= ~device_fault & (dev_flag_n_r | dev_clear); // [RL14]
            if (soft_rst) reset_seen_n_r <= 1'b0;
            else if (status_wr && bus_wdata[STATUS_RESET_FLAG_BIT]) reset_seen_n_r <= 1'b1;
            if (adc_a_valid) adc_a_r <= adc_a_data;
            if (adc_b_valid) adc_b_r <= adc_b_data;
            if (sel_valid) conv_cnt_r <= conv_cnt_r + 4'h1;
            if (state_r == LINK_BOOT || soft_rst) sample_ready_n <= state_nxt == LINK_IDLE; // [RL5]
            else if (sel_valid) sample_ready_n <= 1'b0; // [RL4]
            else if (b_sent) sample_ready_n <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            out_bit_r <= 6'd0;
            out_word_r <= 6'd0;
            crc_out_r <= CRC_SEED;
        end else if (frame_open) begin
            serial_out <= 1'b0; // [RL2]
            serial_out_oe <= 1'b1;
            out_bit_r <= 6'd0;
            out_word_r <= 6'd0;
            crc_out_r <= CRC_SEED; // [RL20]
        end else if (cs_rise) begin
            serial_out_oe <= 1'b0; // [RL2] [RL24]
        end else if (sclk_rise) begin
            serial_out <= out_bit_val; // [RL1] [RL3]
            if (out_word_r < crc_idx) crc_out_r <= crc_step(crc_out_r, out_bit_val, poly_r); // [RL17] [RL27]
            if (out_bit_r == wlen - 6'd1) begin
                out_bit_r <= 6'd0;
                if (out_word_r != 6'h3f) out_word_r <= out_word_r + 6'd1;
            end else begin
                out_bit_r <= out_bit_r + 6'd1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= CONFIG_RESET;
            bus_rdata <= 32'h00000000;
        end else begin
            if (soft_rst) cfg_r <= CONFIG_RESET;
            else if (bus_write && bus_addr == OFS_CONFIG) cfg_r <= bus_wdata[2:0];
            bus_rdata <= bus_read ? rd_mux : 32'h00000000;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_frame_open;
        frame_open;
    endsequence
    sequence s_driven_low;
        serial_out_oe && !serial_out;
    endsequence

    property p_open_drive;
        s_frame_open |=> s_driven_low;
    endproperty
    a_open_drive: assert property (p_open_drive) else $error("output not driven low at frame open"); // [RL2]

    property p_deselect_float;
        cs_rise |=> !serial_out_oe;
    endproperty
    a_deselect_float: assert property (p_deselect_float) else $error("output still driven after deselect"); // [RL2]

    property p_launch_rise_only;
        in_frame && !sclk_rise && !cs_rise |=> $stable(serial_out);
    endproperty
    a_launch_rise_only: assert property (p_launch_rise_only) else $error("output moved off a rising edge"); // [RL1]

    property p_extra_low;
        sclk_rise && out_word_r > crc_idx |=> !serial_out;
    endproperty
    a_extra_low: assert property (p_extra_low) else $error("output not low on extra clocks"); // [RL3]

    property p_ready_fall;
        state_r != LINK_BOOT && !soft_rst && sel_valid |=> !sample_ready_n;
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall on new data"); // [RL4]

    property p_boot_low;
        state_r == LINK_BOOT |=> !sample_ready_n || $past(state_nxt) == LINK_IDLE;
    endproperty
    a_boot_low: assert property (p_boot_low) else $error("ready high before port is ready"); // [RL5]

    property p_comm_once;
        frame_end && !soft_rst |=> comm_r == $past(comm_pend_r) && comm_pend_r == COMM_FLAGS_CLEAR;
    endproperty
    a_comm_once: assert property (p_comm_once) else $error("link fault flags not handed on"); // [RL13]

    property p_crc_reject;
        cmd_end && !cmd_ok && !frame_end |=> !comm_pend_r[COMM_CHECK_BIT] && $stable(lock_r) && !wr_armed_r;
    endproperty
    a_crc_reject: assert property (p_crc_reject) else $error("bad command CRC not rejected"); // [RL18]

    property p_seed;
        s_frame_open |=> crc_in_r == CRC_SEED && crc_out_r == CRC_SEED;
    endproperty
    a_seed: assert property (p_seed) else $error("CRC not seeded with all ones"); // [RL20]

    property p_lock_blocks;
        lock_r && cmd_end && cmd_ok && !lock_safe && !frame_end |=> !wr_armed_r && !rst_armed_r ##1 lock_r;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked port accepted a command"); // [RL22]
endmodule : framed_spi_peripheral_crc

// >>> bench/spi_host_model.sv
// Host controller model that runs framed serial transfers on the link pins
`timescale 1ns/100ps
module spi_host_model (
    output logic chip_select_low,
    output logic serial_clk,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic [31:0] tx [8];
    logic [31:0] rx [8];
    logic oe_open, out_open, after_x;
    initial begin
        chip_select_low = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // Launch at rise; take late in the low phase so the port's filter delay is covered
    task automatic frame(input int nw, input int wb, input int extra);
        int i;
        foreach (rx[k]) rx[k] = 32'h0;
        chip_select_low = 1'b0;
        #400;
        oe_open = serial_out_oe;
        out_open = serial_out;
        for (i = 0; i < nw * wb; i++) begin
            serial_clk = 1'b1;
            serial_in = tx[i / wb][31 - i % wb];
            #100;
            serial_clk = 1'b0;
            #100;
            rx[i / wb][31 - i % wb] = serial_out;
        end
        repeat (extra) begin
            serial_clk = 1'b1;
            #100;
            serial_clk = 1'b0;
            #100;
        end
        #200;
        after_x = serial_out;
        chip_select_low = 1'b1;
        serial_in = ~serial_in;
        #400;
    endtask : frame
endmodule : spi_host_model

// >>> bench/framed_spi_peripheral_crc_bench.sv
// Self-checking bench for the framed serial peripheral port
`timescale 1ns/100ps
module framed_spi_peripheral_crc_bench;
    import spi_frame_pkg::*;
    logic clock, arst_n, adc_a_valid, adc_b_valid, bus_write, bus_read;
    logic chip_select_low, serial_clk, serial_in, serial_out, serial_out_oe, sample_ready_n;
    logic [23:0] adc_a_data, adc_b_data;
    logic [11:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic [9:0] device_fault;
    logic [15:0] ureg0;
    logic rd_next = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    framed_spi_peripheral_crc framed_spi_peripheral_crc_inst (.clock(clock), .arst_n(arst_n),
        .chip_select_low(chip_select_low), .serial_clk(serial_clk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sample_ready_n(sample_ready_n),
        .adc_a_data(adc_a_data), .adc_a_valid(adc_a_valid), .adc_b_data(adc_b_data),
        .adc_b_valid(adc_b_valid), .device_fault(device_fault), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata));
    spi_host_model spi_host_model_inst (.chip_select_low(chip_select_low), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Own CRC, MSB first over padded words
    function automatic logic [15:0] crc_of(input logic [31:0] w [8], input int n, input int wb, input logic ansi);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n * wb; i++) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i / wb][31 - i % wb]) ? (ansi ? POLY_ANSI : POLY_CCITT) : 16'h0000);
        end
        return c;
    endfunction : crc_of
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_write <= wr;
        bus_read <= !wr;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clock);
        bus_write <= 1'b0;
        bus_read <= 1'b0;
        @(negedge clock);
    endtask : bus
    task automatic pulse(input logic [1:0] ab);
        @(posedge clock);
        adc_a_valid <= ab[1];
        adc_b_valid <= ab[0];
        @(posedge clock);
        adc_a_valid <= 1'b0;
        adc_b_valid <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : pulse
    // Four-word frame; st is the expected {comm, lock, response} of the reply
    task automatic xfer(input logic [15:0] cmd, input int wb, input logic ansi, input logic bad, input logic [8:0] st);
        logic [31:0] w [8];
        w = '{default: 32'h0};
        w[0] = {cmd, 16'h0};
        w[1] = {crc_of(w, 1, wb, ansi) ^ {15'h0, bad}, 16'h0};
        spi_host_model_inst.tx = w;
        spi_host_model_inst.frame(4, wb, 2);
        w = spi_host_model_inst.rx;
        chk("status", {23'h0, st}, {23'h0, w[0][31:27], w[0][15:12]});
        chk("word1", rd_next ? {ureg0, 8'h00, 8'h0} : {adc_a_data, 8'h0}, w[1]);
        chk("word2", rd_next ? {16'h0, 8'h01, 8'h0} : {adc_b_data, 8'h0}, w[2]);
        rd_next = (cmd[15:13] == PREFIX_READ);
        chk("out_crc", {crc_of(w, 3, wb, ansi), 16'h0}, w[3]);
        chk("open_drive", 2, {spi_host_model_inst.oe_open, spi_host_model_inst.out_open});
        chk("extra_clocks", 0, spi_host_model_inst.after_x);
        chk("oe_closed", 0, serial_out_oe);
        $display("Frame with command %h done", cmd);
    endtask : xfer
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        {arst_n, adc_a_valid, adc_b_valid, bus_write, bus_read} = 5'h00;
        bus_addr = 12'h000;
        bus_wdata = 32'h0;
        device_fault = 10'h000;
        void'($urandom(32'h8f35));
        ureg0 = $urandom;
        adc_a_data = $urandom;
        adc_b_data = $urandom;
        repeat (3) @(posedge clock);
        chk("ready_in_reset", 0, sample_ready_n);
        chk("oe_in_reset", 0, serial_out_oe);
        arst_n <= 1'b1;
        repeat (60) @(posedge clock);
        chk("ready_after_boot", 1, sample_ready_n);
        pulse(2'b11);
        chk("ready_new_a", 0, sample_ready_n);
        xfer(CMD_NOOP, 24, 1'b0, 1'b0, {4'hf, 1'b0, RESP_FIRST});
        chk("ready_read_out", 1, sample_ready_n);
        xfer(CMD_NOOP, 24, 1'b0, 1'b1, {4'hf, 1'b0, RESP_NOOP});
        xfer(CMD_LOCK, 24, 1'b0, 1'b0, {4'h7, 1'b0, RESP_NOOP});
        xfer(CMD_SOFT_RESET, 24, 1'b0, 1'b0, {4'hf, 1'b1, RESP_LOCK});
        xfer(CMD_UNLOCK, 24, 1'b0, 1'b0, {4'he, 1'b1, RESP_NOOP});
        bus(1'b1, OFS_USER_BASE, {16'h0, ureg0});
        xfer(16'ha001, 24, 1'b0, 1'b0, {4'hf, 1'b0, RESP_UNLOCK});
        xfer(CMD_NOOP, 24, 1'b0, 1'b0, {4'hf, 1'b0, RESP_READ});
        @(posedge clock);
        device_fault <= 10'h001;
        @(posedge clock);
        device_fault <= 10'h000;
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("fault_latched", 0, bus_rdata[8]);
        bus(1'b1, OFS_STATUS, 32'h3ff);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("fault_cleared", 1, bus_rdata[8]);
        bus(1'b1, OFS_CONFIG, 32'h7);
        bus(1'b0, OFS_CONFIG, 32'h0);
        chk("config", 7, bus_rdata);
        bus(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", 0, bus_rdata);
        @(posedge clock);
        adc_b_data <= $urandom;
        pulse(2'b01);
        chk("ready_new_b", 0, sample_ready_n);
        xfer(CMD_NOOP, 32, 1'b1, 1'b0, {4'hf, 1'b0, RESP_NOOP});
        finish_test();
    end
endmodule : framed_spi_peripheral_crc_bench
